// >>> hdl/tfx_top.v
// How it works
// - Every texel component leaves as an eight-bit value.
// - Morton order fills low bits by repeating the component's top bits.
// - An expanded alpha of zero marks the texel fully transparent.
// - Linear order fills low bits of multi-bit components with zeros.
// - A one-bit component is copied into all eight bits in either order.
// - Morton order ignores the stride-select flag.
// - Linear order ignores the level-chain flag; one level only.
// - Linear with stride select takes U size from the stride field.
// - Level-chain textures ignore V size; V equals U.
// - Compressed textures find index data 256 words past the code book.
// - Level-chain base address is the 1x1 level; larger levels follow.
`include "tfx_map.vh"

module tfx_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_ff,
    output reg pready_ff,
    output reg pslverr_ff,
    input wire [31:0] texel_in,
    input wire texel_in_valid,
    output reg [31:0] texel_argb_ff,
    output reg texel_valid_ff,
    output reg texel_clear_ff,
    output reg [10:0] u_size_ff,
    output reg [10:0] v_size_ff,
    output reg [3:0] level_count_ff,
    output reg [20:0] fetch_addr_ff
);

    // ***********************************************
    // Software registers
    // ***********************************************
    reg [31:0] desc_ff;
    reg [5:0] shade_ff;
    reg [4:0] texture_stride_control_ff;

    wire level_chain_flag = desc_ff[`TFX_DESC_MIP];
    wire codebook_compressed_flag = desc_ff[`TFX_DESC_VQ];
    wire scan_linear = desc_ff[`TFX_DESC_SCAN];
    wire stride_sel = desc_ff[`TFX_DESC_STRIDE];
    wire [2:0] pix_fmt = desc_ff[`TFX_DESC_FMT_HI:`TFX_DESC_FMT_LO];
    wire [20:0] base_addr = desc_ff[`TFX_DESC_ADDR_HI:`TFX_DESC_ADDR_LO];

    // ***********************************************
    // Flag resolution
    // ***********************************************
    wire eff_stride = scan_linear & stride_sel;
    wire eff_mip = level_chain_flag & ~scan_linear;
    wire [2:0] u_code = shade_ff[`TFX_SHADE_U_HI:`TFX_SHADE_U_LO];
    wire [2:0] v_code = shade_ff[`TFX_SHADE_V_HI:`TFX_SHADE_V_LO];
    wire [10:0] u_desc = `TFX_MIN_SIZE << u_code;
    wire [10:0] u_stride = {6'h00, texture_stride_control_ff} << `TFX_STRIDE_UNIT;
    reg [10:0] nxt_u_size;
    reg [10:0] nxt_v_size;
    reg [3:0] nxt_levels;
    reg [20:0] nxt_fetch;

    always @* begin
        nxt_u_size = eff_stride ? u_stride : u_desc;
        nxt_v_size = eff_mip ? nxt_u_size : (`TFX_MIN_SIZE << v_code);
        if (eff_mip) begin
            nxt_levels = `TFX_LEVEL_BASE + {1'b0, u_code};
        end else begin
            nxt_levels = `TFX_RST_LEVELS;
        end
        if (codebook_compressed_flag) begin
            nxt_fetch = base_addr + `TFX_CODEBOOK_WORDS;
        end else begin
            nxt_fetch = base_addr;
        end
    end

    // ***********************************************
    // Component split per pixel format
    // ***********************************************
    reg [31:0] raw_bus;
    reg [15:0] width_bus;

    always @* begin
        case (pix_fmt)
            `TFX_FMT_1555: begin
                raw_bus = {7'h00, texel_in[15], 3'h0, texel_in[14:10],
                    3'h0, texel_in[9:5], 3'h0, texel_in[4:0]};
                width_bus = 16'h1555;
            end
            `TFX_FMT_565: begin
                raw_bus = {8'h00, 3'h0, texel_in[15:11], 2'h0, texel_in[10:5],
                    3'h0, texel_in[4:0]};
                width_bus = 16'h0565;
            end
            `TFX_FMT_4444: begin
                raw_bus = {4'h0, texel_in[15:12], 4'h0, texel_in[11:8],
                    4'h0, texel_in[7:4], 4'h0, texel_in[3:0]};
                width_bus = 16'h4444;
            end
            default: begin
                raw_bus = texel_in;
                width_bus = 16'h8888;
            end
        endcase
    end

    // ***********************************************
    // Per-component expansion
    // ***********************************************
    wire [31:0] wide_bus;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_comp
            tfx_expand u_exp (
                .raw(raw_bus[gi*8 +: 8]),
                .width(width_bus[gi*4 +: 4]),
                .linear(scan_linear),
                .wide(wide_bus[gi*8 +: 8])
            );
        end
    endgenerate

    // ***********************************************
    // Texel output stage
    // ***********************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            texel_argb_ff <= 32'h0000_0000;
            texel_valid_ff <= 1'b0;
            texel_clear_ff <= 1'b0;
        end else begin
            texel_valid_ff <= texel_in_valid;
            if (texel_in_valid) begin
                texel_argb_ff <= wide_bus;
                texel_clear_ff <= (wide_bus[31:24] == `TFX_TRANSPARENT);
            end
        end
    end

    // ***********************************************
    // Resolved descriptor outputs
    // ***********************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            u_size_ff <= `TFX_MIN_SIZE;
            v_size_ff <= `TFX_MIN_SIZE;
            level_count_ff <= `TFX_RST_LEVELS;
            fetch_addr_ff <= 21'h000000;
        end else begin
            u_size_ff <= nxt_u_size;
            v_size_ff <= nxt_v_size;
            level_count_ff <= nxt_levels;
            fetch_addr_ff <= nxt_fetch;
        end
    end

    // ***********************************************
    // APB slave
    // ***********************************************
    wire setup = psel & ~penable;
    wire wr_take = psel & penable & pready_ff & pwrite & ~pslverr_ff;
    reg [31:0] nxt_rdata;
    reg nxt_err;

    always @* begin
        nxt_rdata = 32'h0000_0000;
        nxt_err = 1'b0;
        case (paddr)
            `TFX_OFS_DESC: nxt_rdata = desc_ff;
            `TFX_OFS_SHADE: nxt_rdata = {26'h0, shade_ff};
            `TFX_OFS_STRIDE: nxt_rdata = {27'h0, texture_stride_control_ff};
            `TFX_OFS_TEXEL: nxt_rdata = texel_argb_ff;
            `TFX_OFS_RESOLVED: nxt_rdata = {1'b0, texel_clear_ff, eff_mip, eff_stride,
                level_count_ff, 2'h0, v_size_ff, u_size_ff};
            `TFX_OFS_FETCH: nxt_rdata = {11'h0, fetch_addr_ff};
            default: nxt_err = 1'b1;
        endcase
        if (pwrite) begin
            nxt_rdata = 32'h0000_0000;
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= setup;
            if (setup) begin
                prdata_ff <= nxt_rdata;
                pslverr_ff <= nxt_err;
            end else begin
                pslverr_ff <= 1'b0;
            end
        end
    end

    // ***********************************************
    // Register writes
    // ***********************************************
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desc_ff <= `TFX_RST_DESC;
            shade_ff <= `TFX_RST_SHADE;
            texture_stride_control_ff <= `TFX_RST_STRIDE;
        end else if (wr_take) begin
            case (paddr)
                `TFX_OFS_DESC: desc_ff <= pwdata;
                `TFX_OFS_SHADE: shade_ff <= pwdata[5:0];
                `TFX_OFS_STRIDE: begin
                    texture_stride_control_ff <= pwdata[`TFX_STRIDE_HI:`TFX_STRIDE_LO];
                end
                default: desc_ff <= desc_ff;
            endcase
        end
    end

endmodule // tfx_top

// >>> hdl/tfx_map.vh
`ifndef TFX_MAP_VH
`define TFX_MAP_VH

// ***********************************************
// Register offsets
// ***********************************************
`define TFX_OFS_DESC 8'h00
`define TFX_OFS_SHADE 8'h04
`define TFX_OFS_STRIDE 8'h08
`define TFX_OFS_TEXEL 8'h0C
`define TFX_OFS_RESOLVED 8'h10
`define TFX_OFS_FETCH 8'h14

// ***********************************************
// Descriptor fields
// ***********************************************
`define TFX_DESC_MIP 31
`define TFX_DESC_VQ 30
`define TFX_DESC_FMT_HI 29
`define TFX_DESC_FMT_LO 27
`define TFX_DESC_SCAN 26
`define TFX_DESC_STRIDE 25
`define TFX_DESC_ADDR_HI 20
`define TFX_DESC_ADDR_LO 0

// ***********************************************
// Shading word and stride fields
// ***********************************************
`define TFX_SHADE_U_HI 5
`define TFX_SHADE_U_LO 3
`define TFX_SHADE_V_HI 2
`define TFX_SHADE_V_LO 0
`define TFX_STRIDE_HI 4
`define TFX_STRIDE_LO 0

// ***********************************************
// Pixel formats
// ***********************************************
`define TFX_FMT_1555 3'h0
`define TFX_FMT_565 3'h1
`define TFX_FMT_4444 3'h2

// ***********************************************
// Sizes and counts
// ***********************************************
`define TFX_COMP_W 8
`define TFX_MIN_SIZE 11'h008
`define TFX_STRIDE_UNIT 5
`define TFX_CODEBOOK_WORDS 21'h000100
`define TFX_OPAQUE 8'hFF
`define TFX_TRANSPARENT 8'h00

// ***********************************************
// Reset values
// ***********************************************
`define TFX_RST_DESC 32'h0000_0000
`define TFX_RST_SHADE 6'h00
`define TFX_RST_STRIDE 5'h00
`define TFX_RST_LEVELS 4'h1
`define TFX_LEVEL_BASE 4'h4

`endif

// >>> hdl/tfx_expand.v
`include "tfx_map.vh"

// ***********************************************
// One component widened to eight bits
// ***********************************************
module tfx_expand (
    input wire [7:0] raw,
    input wire [3:0] width,
    input wire linear,
    output reg [7:0] wide
);
    integer i;
    integer k;
    always @* begin
        wide = 8'h00;
        k = 0;
        if (width == 4'h0) begin
            wide = `TFX_OPAQUE;
        end else if (width >= 4'h8) begin
            wide = raw;
        end else if (width == 4'h1) begin
            wide = {8{raw[0]}};
        end else if (linear) begin
            wide = raw << (4'h8 - width);
        end else begin
            for (i = 0; i < 8; i = i + 1) begin
                k = width - 1 - ((7 - i) % width);
                wide[i] = raw[k];
            end
        end
    end
endmodule // tfx_expand

// >>> tb/tfx_chk.sv
module tfx_chk (
    input logic pclk,
    input logic presetn,
    input logic psel,
    input logic penable,
    input logic [7:0] paddr,
    input logic pready_ff,
    input logic pslverr_ff,
    input logic texel_in_valid,
    input logic texel_valid_ff,
    input logic texel_clear_ff,
    input logic [31:0] texel_argb_ff,
    input logic [10:0] u_size_ff,
    input logic [10:0] v_size_ff,
    input logic [3:0] level_count_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    // ***********************************************
    // Port checks
    // ***********************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (psel && !penable |=> pready_ff)
        else $error("no ready after setup");
    a_ready_access: assert property (pready_ff |-> psel && penable)
        else $error("ready outside access");
    a_unmapped_err: assert property (pready_ff && paddr[1:0] == 2'h0 |->
        pslverr_ff == (paddr > 8'h14)) else $error("wrong slave error");
    a_texel_answer: assert property (texel_in_valid |=> texel_valid_ff)
        else $error("texel not answered");
    a_texel_cause: assert property (texel_valid_ff |-> $past(texel_in_valid))
        else $error("texel valid without input");
    a_argb_hold: assert property (!texel_valid_ff |-> $stable(texel_argb_ff))
        else $error("texel changed without valid");
    a_clear_alpha: assert property (texel_valid_ff |->
        texel_clear_ff == (texel_argb_ff[31:24] == 8'h00)) else $error("clear flag wrong");
    a_chain_square: assert property (level_count_ff != 4'h1 |->
        v_size_ff == u_size_ff) else $error("chain not square");
    a_chain_levels: assert property (level_count_ff != 4'h1 |->
        u_size_ff == (11'h008 << (level_count_ff - 4'h4))) else $error("level count wrong");
    c_clear: cover property (texel_valid_ff && texel_clear_ff);
    c_err: cover property (pslverr_ff);
    c_chain: cover property (level_count_ff != 4'h1);
endmodule // tfx_chk

bind tfx_top tfx_chk i_tfx_chk(.pclk, .presetn, .psel, .penable, .paddr, .pready_ff, .pslverr_ff,
    .texel_in_valid, .texel_valid_ff, .texel_clear_ff, .texel_argb_ff, .u_size_ff, .v_size_ff,
    .level_count_ff);

// >>> tb/tfx_fetch_model.sv
module tfx_fetch_model (
    input logic pclk,
    input logic go,
    input logic [31:0] word,
    output logic [31:0] texel_in,
    output logic texel_in_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    // ***********************************************
    // Texel source, one cycle per word
    // ***********************************************
    initial begin
        texel_in = 32'h0;
        texel_in_valid = 1'b0;
    end
    always @(posedge pclk) begin
        texel_in_valid <= go;
        texel_in <= go ? word : ~texel_in;
    end
endmodule // tfx_fetch_model

// >>> tb/test_texel_format_color_expand.sv
module test_texel_format_color_expand;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, go = 0, er;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, word = 32'h0, prdata_ff, texel_in, texel_argb_ff, rd;
    logic pready_ff, pslverr_ff, texel_in_valid, texel_valid_ff, texel_clear_ff;
    logic [10:0] u_size_ff, v_size_ff;
    logic [3:0] level_count_ff;
    logic [20:0] fetch_addr_ff;
    int fails = 0, n_tests = 0, cyc = 0;
    tfx_top i_tfx_top(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_ff,
        .pready_ff, .pslverr_ff, .texel_in, .texel_in_valid, .texel_argb_ff, .texel_valid_ff,
        .texel_clear_ff, .u_size_ff, .v_size_ff, .level_count_ff, .fetch_addr_ff);
    tfx_fetch_model i_tfx_fetch_model(.pclk, .go, .word, .texel_in, .texel_in_valid);
    // ***********************************************
    // Helpers
    // ***********************************************
    initial forever #12.5 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            final_report;
        end
    end
    task final_report;
        $display("tests %0d fails %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready_ff !== 1'b1);
        rd = prdata_ff;
        er = pslverr_ff;
        {psel, penable} <= 2'b00;
    endtask
    task tx(input logic [31:0] w);
        @(posedge pclk);
        {go, word} <= {1'b1, w};
        @(posedge pclk);
        go <= 0;
        @(posedge pclk);
        @(negedge pclk);
    endtask
    function automatic logic [7:0] c(input logic [7:0] v, input int n, input logic l);
        logic [7:0] r;
        r = v << (8 - n);
        for (int i = 7 - n; i >= 0; i--) r[i] = (n == 1 || !l) ? r[i + n] : 1'b0;
        return r;
    endfunction
    function automatic logic [31:0] ex(input logic [31:0] w, input int f, input logic l);
        case (f)
            0: return {c(w[15], 1, l), c(w[14:10], 5, l), c(w[9:5], 5, l), c(w[4:0], 5, l)};
            1: return {8'hFF, c(w[15:11], 5, l), c(w[10:5], 6, l), c(w[4:0], 5, l)};
            2: return {c(w[15:12], 4, l), c(w[11:8], 4, l), c(w[7:4], 4, l), c(w[3:0], 4, l)};
            default: return w;
        endcase
    endfunction
    // ***********************************************
    // Scenarios
    // ***********************************************
    task sc_expand;
        logic [31:0] w, e;
        for (int f = 0; f < 4; f++) for (int l = 0; l < 2; l++) for (int k = 0; k < 2; k++) begin
            w = k ? 32'h5A3C_B5A3 : 32'h0000_4C7E;
            e = ex(w, f, l[0]);
            apb(1, 8'h00, {2'h0, f[2:0], l[0], 26'h0});
            tx(w);
            chk(texel_valid_ff, 1);
            chk(texel_argb_ff, e);
            chk(texel_clear_ff, e[31:24] == 8'h00);
            apb(0, 8'h0C, 0);
            chk(rd, e);
        end
    endtask
    task sz(input logic [3:0] k, input logic [5:0] sh, input logic [10:0] eu,
        input logic [10:0] ev, input logic [3:0] el, input logic [20:0] ef);
        apb(1, 8'h04, {26'h0, sh});
        apb(1, 8'h00, {k[3:2], 3'h0, k[1:0], 4'h0, 21'h000800});
        @(posedge pclk);
        @(negedge pclk);
        chk({u_size_ff, v_size_ff}, {eu, ev});
        chk({level_count_ff, fetch_addr_ff}, {el, ef});
        apb(0, 8'h10, 0);
        chk(rd, {2'h0, k[3] & ~k[1], k[1] & k[0], el, 2'h0, ev, eu});
        apb(0, 8'h14, 0);
        chk(rd, {11'h0, ef});
    endtask
    task sc_sizes;
        apb(1, 8'h08, 32'h3);
        apb(0, 8'h08, 0);
        chk(rd, 32'h3);
        sz(4'h0, 6'h19, 11'd64, 11'd16, 4'h1, 21'h000800);
        sz(4'h8, 6'h15, 11'd32, 11'd32, 4'h6, 21'h000800);
        sz(4'hA, 6'h15, 11'd32, 11'd256, 4'h1, 21'h000800);
        sz(4'h3, 6'h15, 11'd96, 11'd256, 4'h1, 21'h000800);
        sz(4'h1, 6'h15, 11'd32, 11'd256, 4'h1, 21'h000800);
        sz(4'hC, 6'h15, 11'd32, 11'd32, 4'h6, 21'h000900);
    endtask
    task sc_apb;
        chk({u_size_ff, v_size_ff, level_count_ff}, {11'd8, 11'd8, 4'h1});
        apb(0, 8'hFC, 32'hFFFF_FFFF);
        chk(er, 1);
        chk(rd, 32'h0);
        apb(1, 8'hF0, 32'hFFFF_FFFF);
        chk(er, 1);
        apb(1, 8'h0C, 32'hFFFF_FFFF);
        chk(er, 0);
        apb(0, 8'h00, 0);
        chk(er, 0);
        chk(rd, 32'h0);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        sc_apb;
        sc_expand;
        sc_sizes;
        final_report;
    end
endmodule // test_texel_format_color_expand
